// ===== pev_pkg.sv
// constants, field layouts and carrier types of the exception vectoring block
package pev_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address on the bus is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_VECTOR_BASE   = 8'h10;
    localparam logic [7:0]  IDX_CFG_SELECT    = 8'h17;
    localparam logic [7:0]  IDX_CFG_WINDOW    = 8'h18;
    localparam int unsigned WINDOW_SIZE       = 8;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SEL_LSB           = 3;
    localparam int unsigned SEL_MSB           = 6;
    localparam int unsigned LEVEL_MSB         = 2;
    localparam int unsigned BASE_LSB          = 9;
    localparam logic [15:0] VECTOR_BASE_RESET = 16'hFFFE;
    localparam logic [3:0]  CFG_SELECT_RESET  = 4'h0;
    localparam logic [2:0]  LEVEL_RESET       = 3'h1;
    localparam logic [2:0]  LEVEL_TOP         = 3'h7;

    // ------------------------------------------------------------------
    // vector locations
    // ------------------------------------------------------------------
    localparam logic [23:0] RESET_VECTOR      = 24'hFFFFFC;
    localparam logic [8:0]  OFS_TRAP_PAGE1    = 9'h1F8;
    localparam logic [8:0]  OFS_TRAP_PAGE2    = 9'h1F4;
    localparam logic [8:0]  OFS_SOFTWARE      = 9'h1F0;
    localparam logic [8:0]  OFS_SUPERVISOR    = 9'h1EC;
    localparam logic [8:0]  OFS_MACHINE       = 9'h1E8;
    localparam logic [8:0]  OFS_SPURIOUS      = 9'h1DC;
    localparam logic [8:0]  OFS_X_PIN         = 9'h1D8;
    localparam logic [8:0]  OFS_I_PIN         = 9'h1D4;
    localparam logic [8:0]  OFS_PERIPH_LO     = 9'h010;
    localparam logic [8:0]  OFS_PERIPH_HI     = 9'h1D0;
    localparam logic [6:0]  SLOT_LO           = 7'h04;
    localparam logic [6:0]  SLOT_I_PIN        = 7'h75;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       low_power;
        logic       x_mask;
        logic       i_mask;
        logic [2:0] processing_level;
    } pev_cpu_t;

    typedef struct packed {
        logic reset_req;
        logic trap_page1;
        logic trap_page2;
        logic software_interrupt;
        logic supervisor_call_request;
        logic machine_exception;
        logic spurious;
    } pev_nmi_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] vector;
        logic [2:0]  level;
    } pev_exc_t;

    typedef enum logic [1:0] {
        PEV_BUS_IDLE = 2'b00,
        PEV_BUS_DATA = 2'b01
    } pev_bus_t;

endpackage

// ===== pev_vectoring.sv
// prioritised exception vectoring with an ahb-lite register slave
`timescale 1ns/1ps
//
// Notes on behaviour
// - vector base is register bits plus nine zeros
// - reset vector always at FFFFFC
// - page-one opcode trap uses base plus 1F8
// - page-two opcode trap uses base plus 1F4
// - software interrupt uses base plus 1F0
// - supervisor call uses base plus 1EC
// - machine exception uses base plus 1E8
// - spurious interrupt uses base plus 1DC
// - x pin uses 1D8, gated by x mask
// - i pin uses 1D4, gated by i mask
// - up to 113 peripheral requests, 010..1D0
// - each i-maskable request has level one-seven
// - lower or equal levels blocked while servicing
// - winning request's vector handed to cpu
// - wake on eligible request or x pin
// - vector base, reserved, select register placement
// - vector base resets to FFFE
// - select bits 6:3 pick block of eight
// - window entries ascend with vector address
module pev_vectoring
    import pev_pkg::*;
#(
    parameter int unsigned NUM_SLOTS = 128
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire pev_cpu_t    cpu,
    input  wire pev_nmi_t    nmi,
    input  wire logic        x_masked_pin_request,
    input  wire logic        i_masked_pin_request,
    input  wire logic [NUM_SLOTS-1:0] periph_req,
    output pev_exc_t         exc,
    output logic             wakeup
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (NUM_SLOTS != 128) begin : g_bad_slots
        $error("pev_vectoring: slot count must be 128");
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // true for slots that own a priority level field and a vector
    function automatic logic is_cfg_slot(input logic [6:0] slot);
        is_cfg_slot = (slot >= SLOT_LO) && (slot <= SLOT_I_PIN);
    endfunction

    // vector address from the base register and a table offset
    function automatic logic [23:0] vec_at(input logic [15:0] base, input logic [8:0] ofs);
        vec_at = {base[15:1], ofs};
    endfunction

    // ------------------------------------------------------------------
    // registers and bus state
    // ------------------------------------------------------------------
    logic [15:0] vector_base;
    logic [3:0]  cfg_select;
    logic [2:0]  priority_level_field [NUM_SLOTS];
    pev_bus_t    bus_phase;
    logic        pend_write;
    logic [7:0]  pend_idx;
    logic        pend_mapped;

    logic        addr_take;
    logic        addr_ok;
    logic [6:0]  win_slot;

    // address phase is taken only on a selected, ready, non-idle transfer
    assign addr_take = hsel && hready && htrans[1];
    assign addr_ok   = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign win_slot  = {cfg_select, pend_idx[2:0]};

    // one wait state per transfer so write data and readback never race
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_phase   <= PEV_BUS_IDLE;
            hreadyout   <= 1'b1;
            pend_write  <= 1'b0;
            pend_idx    <= 8'h00;
            pend_mapped <= 1'b0;
        end else begin
            case (bus_phase)
                PEV_BUS_IDLE: begin
                    if (addr_take) begin
                        bus_phase   <= PEV_BUS_DATA;
                        hreadyout   <= 1'b0;
                        pend_write  <= hwrite;
                        pend_idx    <= haddr[9:2];
                        pend_mapped <= addr_ok;
                    end
                end
                PEV_BUS_DATA: begin
                    bus_phase <= PEV_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    bus_phase <= PEV_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // responses are always okay; unmapped reads give zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    logic do_write;
    assign do_write = (bus_phase == PEV_BUS_DATA) && pend_write && pend_mapped;

    // base and select; bit 0 of the base is hard zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vector_base <= VECTOR_BASE_RESET;
            cfg_select  <= CFG_SELECT_RESET;
        end else if (do_write) begin
            if (pend_idx == IDX_VECTOR_BASE) begin
                vector_base <= {hwdata[15:1], 1'b0};
            end
            if (pend_idx == IDX_CFG_SELECT) begin
                cfg_select <= hwdata[SEL_MSB:SEL_LSB];
            end
        end
    end

    // level table; slots without a vector keep their field but never win
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                priority_level_field[i] <= LEVEL_RESET;
            end
        end else if (do_write && (pend_idx[7:3] == IDX_CFG_WINDOW[7:3])) begin
            priority_level_field[win_slot] <= hwdata[LEVEL_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h00000000;
        if (pend_mapped && !pend_write) begin
            if (pend_idx == IDX_VECTOR_BASE) begin
                next_rdata = {16'h0000, vector_base};
            end else if (pend_idx == IDX_CFG_SELECT) begin
                next_rdata = {25'h0000000, cfg_select, 3'h0};
            end else if (pend_idx[7:3] == IDX_CFG_WINDOW[7:3]) begin
                next_rdata = {29'h00000000, priority_level_field[win_slot]};
            end
        end
    end

    // read data is captured as the wait state ends
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (bus_phase == PEV_BUS_DATA) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // eligibility of the i-maskable slots
    // ------------------------------------------------------------------
    logic [NUM_SLOTS-1:0] slot_eligible;

    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
        logic req;
        // the i pin shares the table slot just above the peripherals
        assign req = (g == int'(SLOT_I_PIN)) ? (periph_req[g] | i_masked_pin_request)
                                             : periph_req[g];
        assign slot_eligible[g] = req && is_cfg_slot(7'(g)) && !cpu.i_mask
                                  && (priority_level_field[g] > cpu.processing_level);
    end

    // ------------------------------------------------------------------
    // level arbitration over the slots
    // ------------------------------------------------------------------
    logic [2:0] best_level;
    logic [6:0] best_slot;

    // ascending scan with >= lets the higher vector address take a tie
    always_comb begin
        best_level = 3'h0;
        best_slot  = 7'h00;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot_eligible[i] && (priority_level_field[i] >= best_level)) begin
                best_level = priority_level_field[i];
                best_slot  = 7'(i);
            end
        end
    end

    // ------------------------------------------------------------------
    // overall priority and vector selection
    // ------------------------------------------------------------------
    pev_exc_t next_exc;
    logic     x_pin_take;
    logic     next_wake;

    assign x_pin_take = x_masked_pin_request && !cpu.x_mask;

    // fixed order: reset, traps, calls, machine, x pin, levels, spurious
    always_comb begin
        next_exc = '{valid: 1'b1, vector: 24'h000000, level: LEVEL_TOP};
        if (nmi.reset_req) begin
            next_exc.vector = RESET_VECTOR;
        end else if (nmi.trap_page1) begin
            next_exc.vector = vec_at(vector_base, OFS_TRAP_PAGE1);
        end else if (nmi.trap_page2) begin
            next_exc.vector = vec_at(vector_base, OFS_TRAP_PAGE2);
        end else if (nmi.software_interrupt) begin
            next_exc.vector = vec_at(vector_base, OFS_SOFTWARE);
        end else if (nmi.supervisor_call_request) begin
            next_exc.vector = vec_at(vector_base, OFS_SUPERVISOR);
        end else if (nmi.machine_exception) begin
            next_exc.vector = vec_at(vector_base, OFS_MACHINE);
        end else if (x_pin_take) begin
            next_exc.vector = vec_at(vector_base, OFS_X_PIN);
        end else if (best_level != 3'h0) begin
            next_exc.vector = vec_at(vector_base, {best_slot, 2'h0});
            next_exc.level  = best_level;
        end else if (nmi.spurious) begin
            next_exc.vector = vec_at(vector_base, OFS_SPURIOUS);
        end else begin
            next_exc.valid = 1'b0;
            next_exc.level = 3'h0;
        end
    end

    // the x pin wakes the core even while its mask is set
    assign next_wake = cpu.low_power && (next_exc.valid || x_masked_pin_request);

    // presented vector and wake are registered for clean cpu timing
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exc    <= '{valid: 1'b0, vector: 24'h000000, level: 3'h0};
            wakeup <= 1'b0;
        end else begin
            exc    <= next_exc;
            wakeup <= next_wake;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic nmi_upper;
    assign nmi_upper = nmi.reset_req | nmi.trap_page1 | nmi.trap_page2
                       | nmi.software_interrupt | nmi.supervisor_call_request
                       | nmi.machine_exception;

    a_base_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!nmi.reset_req && (nmi_upper || x_pin_take || best_level != 3'h0))
        |=> exc.valid && (exc.vector[23:BASE_LSB] == $past(vector_base[15:1])))
        else $error("vector does not sit on the base");

    a_reset_vector: assert property (@(posedge sys_clk) disable iff (sys_rst)
        nmi.reset_req |=> exc.valid && exc.vector == RESET_VECTOR)
        else $error("reset vector moved");

    a_trap_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (nmi.trap_page1 && !nmi.reset_req)
        |=> exc.vector[8:0] == OFS_TRAP_PAGE1)
        else $error("page one trap vector wrong");

    a_trap_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (nmi.trap_page2 && !nmi.reset_req && !nmi.trap_page1)
        |=> exc.vector[8:0] == OFS_TRAP_PAGE2)
        else $error("page two trap vector wrong");

    a_soft_call: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (nmi.software_interrupt && !nmi.reset_req && !nmi.trap_page1
         && !nmi.trap_page2) |=> exc.vector[8:0] == OFS_SOFTWARE)
        else $error("software interrupt vector wrong");

    a_x_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu.x_mask && !nmi_upper && !nmi.spurious && best_level == 3'h0)
        |=> !exc.valid)
        else $error("masked x pin was vectored");

    a_spurious_last: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (nmi.spurious && !nmi_upper && !x_pin_take && best_level == 3'h0)
        ##1 exc.valid |-> exc.vector[8:0] == OFS_SPURIOUS)
        else $error("spurious vector wrong");

    a_level_nest: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (exc.valid && exc.vector[8:0] <= OFS_I_PIN)
        |-> exc.level > $past(cpu.processing_level))
        else $error("level not above processing level");

    a_x_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu.low_power && x_masked_pin_request) |=> wakeup)
        else $error("x pin did not wake");

    a_base_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(sys_rst) |-> vector_base == VECTOR_BASE_RESET)
        else $error("vector base reset value wrong");

    a_super_call: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (nmi.supervisor_call_request && !nmi.reset_req && !nmi.trap_page1
         && !nmi.trap_page2 && !nmi.software_interrupt)
        |=> exc.vector[8:0] == OFS_SUPERVISOR)
        else $error("supervisor call vector wrong");

    a_machine_exc: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (nmi.machine_exception && !nmi.reset_req && !nmi.trap_page1 && !nmi.trap_page2
         && !nmi.software_interrupt && !nmi.supervisor_call_request)
        |=> exc.vector[8:0] == OFS_MACHINE)
        else $error("machine exception vector wrong");

    a_i_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cpu.i_mask && !nmi_upper && !x_pin_take && !nmi.spurious)
        |=> !exc.valid)
        else $error("masked i request was vectored");

    a_wake_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (exc.valid && $past(cpu.low_power)) |-> wakeup)
        else $error("valid vector did not wake");

    a_select_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (do_write && pend_idx == IDX_CFG_SELECT)
        |=> cfg_select == $past(hwdata[SEL_MSB:SEL_LSB]))
        else $error("select register write lost");

endmodule

// ===== pev_cpu_model.sv
// cpu core stand-in: drives the masks and takes the vectors that the block hands over
`timescale 1ns/1ps
module pev_cpu_model
    import pev_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire pev_exc_t   exc,
    input  wire pev_cpu_t   cmd,
    input  wire logic       take_en,
    input  wire logic [3:0] take_wait,
    output pev_cpu_t        cpu,
    output logic [23:0]     taken
);
    logic [3:0] wait_cnt;

    // --------------------------------------------------------------
    // core state
    // --------------------------------------------------------------
    // masks lag the bench by one cycle, as a real core's status word would;
    // a taken request raises the level after take_wait cycles, so slow cores nest too
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu <= '0;
            wait_cnt <= 4'h0;
            taken <= 24'h000000;
        end else begin
            cpu.low_power <= cmd.low_power;
            cpu.x_mask <= cmd.x_mask;
            cpu.i_mask <= cmd.i_mask;
            wait_cnt <= (take_en && exc.valid) ? wait_cnt + 4'h1 : 4'h0;
            if (take_en && exc.valid && wait_cnt >= take_wait) begin
                cpu.processing_level <= exc.level;
                taken <= exc.vector;
                wait_cnt <= 4'h0;
            end else if (!take_en) begin
                cpu.processing_level <= cmd.processing_level;
            end
        end
    end
endmodule

// ===== tb_prioritised_exception_vectoring.sv
// self-checking bench for the exception vectoring block and its register slave
`timescale 1ns/1ps
module tb_prioritised_exception_vectoring
    import pev_pkg::*;
;
    logic         sys_clk;
    logic         sys_rst;
    logic         hsel;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [31:0]  hwdata;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    pev_cpu_t     cpu;
    pev_cpu_t     cmd;
    pev_nmi_t     nmi;
    logic         x_pin;
    logic         i_pin;
    logic [127:0] periph;
    pev_exc_t     exc;
    logic         wakeup;
    logic         take_en;
    logic [3:0]   take_wait;
    logic [23:0]  taken;
    logic [15:0]  tb_base;
    logic [31:0]  rd;
    int           miscompares;
    int           n_checks;

    pev_vectoring i_pev_vectoring (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cpu(cpu), .nmi(nmi), .x_masked_pin_request(x_pin),
        .i_masked_pin_request(i_pin), .periph_req(periph), .exc(exc), .wakeup(wakeup)
    );

    pev_cpu_model i_pev_cpu_model (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .exc(exc), .cmd(cmd),
        .take_en(take_en), .take_wait(take_wait), .cpu(cpu), .taken(taken)
    );

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] adr(input logic [7:0] idx);
        return {22'h000000, idx, 2'b00};
    endfunction

    function automatic logic [23:0] vec(input logic [8:0] ofs);
        return {tb_base[15:1], ofs};
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 200);
        if (n >= 200) miscompares++;
        rd = hrdata;
        hsel <= 1'b0;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(adr(idx), 1'b1, d);
    endtask

    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic chk_exc(input logic v, input logic [8:0] ofs, input logic [2:0] lvl);
        chk("exc_valid", {31'h0, exc.valid}, {31'h0, v});
        chk("exc_vector", {8'h00, exc.vector}, {8'h00, vec(ofs)});
        chk("exc_level", {29'h0, exc.level}, {29'h0, lvl});
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset_regs();
        rdchk("base", adr(IDX_VECTOR_BASE), 32'h0000FFFE);
        rdchk("select", adr(IDX_CFG_SELECT), 32'h0);
        for (int k = 0; k < 8; k++) begin
            rdchk("level", adr(IDX_CFG_WINDOW + k[7:0]), 32'h1);
        end
        rdchk("reserved", adr(8'h12), 32'h0);
        $display("test reset_regs done");
    endtask

    // bit 0 of the base is not stored, and aliases must not reach it
    task automatic t_regs();
        wr(IDX_VECTOR_BASE, 32'h00001235);
        tb_base = 16'h1234;
        rdchk("base", adr(IDX_VECTOR_BASE), 32'h00001234);
        wr(8'h14, 32'hFFFFFFFF);
        rdchk("reserved", adr(8'h14), 32'h0);
        xfer(32'h00000440, 1'b1, 32'h0000ABCD);
        rdchk("unmapped", 32'h00000440, 32'h0);
        rdchk("base", adr(IDX_VECTOR_BASE), 32'h00001234);
        $display("test regs done");
    endtask

    // all lower sources stay raised, so each step also proves the order
    task automatic t_nmi();
        logic [8:0] ofs [7];
        ofs = '{OFS_SPURIOUS, OFS_MACHINE, OFS_SUPERVISOR, OFS_SOFTWARE,
                OFS_TRAP_PAGE2, OFS_TRAP_PAGE1, 9'h000};
        for (int i = 6; i >= 0; i--) begin
            nmi <= pev_nmi_t'(7'((8'h02 << i) - 8'h01));
            wt(3);
            chk("nmi_vec", {8'h00, exc.vector},
                {8'h00, (i == 6) ? RESET_VECTOR : vec(ofs[i])});
            chk("nmi_valid", {31'h0, exc.valid}, 32'h1);
        end
        nmi <= '0;
        $display("test nmi done");
    endtask

    // cmd bits: low_power, x_mask, i_mask, level[2:0]
    task automatic t_pins();
        x_pin <= 1'b1;
        wt(3);
        chk_exc(1'b1, OFS_X_PIN, 3'h7);
        cmd <= 6'h10;
        wt(3);
        chk("x_masked", {31'h0, exc.valid}, 32'h0);
        cmd <= 6'h30;
        wt(3);
        chk("wake_x", {31'h0, wakeup}, 32'h1);
        x_pin <= 1'b0;
        i_pin <= 1'b1;
        wt(3);
        chk_exc(1'b1, OFS_I_PIN, 3'h1);
        chk("wake_i", {31'h0, wakeup}, 32'h1);
        cmd <= 6'h28;
        wt(3);
        chk("i_masked", {31'h0, exc.valid}, 32'h0);
        chk("no_wake", {31'h0, wakeup}, 32'h0);
        i_pin <= 1'b0;
        cmd <= 6'h00;
        $display("test pins done");
    endtask

    // tie, blocking by the core's level, nesting, and a far window block
    task automatic t_levels();
        wr(IDX_CFG_SELECT, 32'h0);
        wr(IDX_CFG_WINDOW + 8'h4, 32'h3);
        wr(IDX_CFG_WINDOW + 8'h5, 32'h3);
        wr(IDX_CFG_WINDOW + 8'h6, 32'h2);
        periph[6:4] <= 3'b111;
        wt(3);
        chk_exc(1'b1, 9'h014, 3'h3);
        take_wait <= 4'h2;
        take_en <= 1'b1;
        wt(8);
        chk("taken_lvl", {29'h0, cpu.processing_level}, 32'h3);
        chk("blocked", {31'h0, exc.valid}, 32'h0);
        wr(IDX_CFG_WINDOW + 8'h7, 32'h5);
        periph[7] <= 1'b1;
        wt(8);
        chk("nested", {8'h00, taken}, {8'h00, vec(9'h01C)});
        chk("nested_lvl", {29'h0, cpu.processing_level}, 32'h5);
        take_en <= 1'b0;
        periph <= '0;
        wr(IDX_CFG_SELECT, 32'h70);
        wr(IDX_CFG_WINDOW + 8'h3, 32'h7);
        wr(IDX_CFG_WINDOW + 8'h4, 32'h2);
        periph[4] <= 1'b1;
        periph[116:115] <= 2'b11;
        wt(3);
        chk_exc(1'b1, 9'h1CC, 3'h7);
        rdchk("select", adr(IDX_CFG_SELECT), 32'h70);
        rdchk("window3", adr(IDX_CFG_WINDOW + 8'h3), 32'h7);
        wr(IDX_CFG_WINDOW + 8'h3, 32'h1);
        wr(IDX_CFG_WINDOW + 8'h4, 32'h7);
        wt(3);
        chk_exc(1'b1, OFS_PERIPH_HI, 3'h7);
        periph <= '0;
        $display("test levels done");
    endtask

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        miscompares = 0;
        n_checks = 0;
        tb_base = VECTOR_BASE_RESET;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        cmd = 6'h00;
        nmi = '0;
        x_pin = 1'b0;
        i_pin = 1'b0;
        periph = '0;
        take_en = 1'b0;
        take_wait = 4'h0;
        wt(20);
        sys_rst <= 1'b0;
        t_reset_regs();
        t_regs();
        t_nmi();
        t_pins();
        t_levels();
        give_verdict();
    end

    // the tests need about two hundred cycles; a hundred times that means a hang
    initial begin
        #200us;
        miscompares++;
        give_verdict();
    end
endmodule
